// File: fault_latch_pkg.sv
// Shared constants and carriers for the output fault latch and retry block
package fault_latch_pkg;

    localparam int unsigned NUM_OUTPUTS      = 4;
    localparam int unsigned RETRY_LIMIT      = 16;
    localparam int unsigned RETRY_CNT_W      = 5;
    localparam int unsigned CLK_FREQ_HZ      = 100_000_000;
    localparam int unsigned RETRY_PERIOD_US  = 150;
    localparam int unsigned RETRY_CYCLES     = (RETRY_PERIOD_US * (CLK_FREQ_HZ / 1_000_000));

    // Over-current profile selection
    localparam logic [1:0] PROFILE_HID      = 2'h0;
    localparam logic [1:0] PROFILE_BULB_55W = 2'h1;
    localparam logic [1:0] PROFILE_BULB_28W = 2'h2;

    // Steady-state levels: default is the second low level
    localparam logic [1:0] STEADY_DEFAULT_SEL = 2'h0;
    localparam logic [1:0] LEVEL_LOW1         = 2'h0;
    localparam logic [1:0] LEVEL_LOW2         = 2'h1;
    localparam logic [1:0] LEVEL_LOW3         = 2'h2;
    localparam logic [1:0] LEVEL_LOW4         = 2'h3;

    localparam logic [1:0] INRUSH_SLOPE_DEFAULT = 2'h0;

    // Per-output over-current configuration
    typedef struct packed {
        logic [1:0] profile;
        logic [1:0] inrush_slope_select;
        logic       skip_first_high_step;
        logic [1:0] steady_limit_select;
        logic       cooling_emulation_enable;
        logic [1:0] cooling_slope_select;
    } oc_cfg_t;

    // Configuration actually applied to the over-current detector
    typedef struct packed {
        logic       inrush_active;
        logic [1:0] profile;
        logic [1:0] inrush_slope_select;
        logic       skip_first_high_step;
        logic [1:0] steady_level;
        logic       cooling_active;
        logic [1:0] cooling_slope_select;
    } oc_apply_t;

    // Sticky status seen by the host
    typedef struct packed {
        logic [NUM_OUTPUTS-1:0] thermal_shutdown_flags;
        logic [NUM_OUTPUTS-1:0] overcurrent_flags;
        logic [NUM_OUTPUTS-1:0] short_circuit_flags;
        logic                   supply_high_flag;
        logic                   supply_low_flag;
    } fault_status_t;

    localparam fault_status_t STATUS_RESET = '0;

endpackage

// File: output_fault_latch_retry.sv
// Per-output fault latching, clear-on-read status and auto-retry
//
// Operation
// - Overheat while on latches output off and fault pin low
// - Overheat while off pulls fault pin low only while hot
// - Overheat, over-current and supply-low latches release on condition gone plus retry, toggle, or reset
// - Overheat sets thermal flag; host read clears it
// - Eight-step profile: HID default, 55 W or 28 W selectable per output
// - Inrush profile on each request rising edge and each retry
// - Slope select sets inrush speed; skip bit drops first high step
// - Steady limit defaults to second low level; field picks others
// - Over-current latches output and pin; flag set, cleared on read
// - Cooling emulation in normal PWM mode with HID profile and enable
// - Short latches off, flag set; only toggle, reset or logic supply fail releases
// - Over-voltage forces all off and pin low; flag clear on read
// - Protect disable keeps outputs on; flag still warns
// - Fail-safe mode: over-voltage protection follows reset input level
// - Under-voltage forces outputs off, pin low, sets supply-low flag
// - Recovery with all off releases pin; flag held until read
// - Recovery with output on keeps pin low until delatch
// - Logic supply fail or power-on reset clears all latches
// - Retry request from overcurrent, thermal or supply-low flag
// - Retry after one period; at most 16 attempts per output
// - Mode transitions reset the retry counters
// - Each retry restores the default inrush slope and first high step
// - Turn-on request from direct input or on bit
`timescale 1ns/1ps

module output_fault_latch_retry #(
    parameter int unsigned RETRY_CYCLES = fault_latch_pkg::RETRY_CYCLES,
    parameter int unsigned RETRY_LIMIT  = fault_latch_pkg::RETRY_LIMIT
) (
    input  wire logic                                       core_clk,
    input  wire logic                                       arst_n,
    input  wire logic [fault_latch_pkg::NUM_OUTPUTS-1:0]    direct_in,
    input  wire logic [fault_latch_pkg::NUM_OUTPUTS-1:0]    direct_disable,
    input  wire logic [fault_latch_pkg::NUM_OUTPUTS-1:0]    on_bit,
    input  wire logic                                       pwm_enable,
    input  wire logic                                       failsafe_mode,
    input  wire logic                                       reset_pin,
    input  wire logic                                       supply_high_protect_disable,
    input  wire logic                                       logic_supply_fail,
    input  wire logic                                       supply_por,
    input  wire logic [fault_latch_pkg::NUM_OUTPUTS-1:0]    over_temp,
    input  wire logic [fault_latch_pkg::NUM_OUTPUTS-1:0]    over_current,
    input  wire logic [fault_latch_pkg::NUM_OUTPUTS-1:0]    severe_short,
    input  wire logic                                       supply_high,
    input  wire logic                                       supply_low,
    input  wire fault_latch_pkg::oc_cfg_t [fault_latch_pkg::NUM_OUTPUTS-1:0] oc_cfg,
    input  wire logic                                       status_read,
    output logic [fault_latch_pkg::NUM_OUTPUTS-1:0]         output_enable,
    output fault_latch_pkg::oc_apply_t [fault_latch_pkg::NUM_OUTPUTS-1:0] oc_apply,
    output fault_latch_pkg::fault_status_t                  status,
    output logic                                            fault_pin_n,
    output logic [fault_latch_pkg::NUM_OUTPUTS-1:0]         retry_exhausted
);

    localparam int unsigned N = fault_latch_pkg::NUM_OUTPUTS;
    localparam int unsigned RC_W = fault_latch_pkg::RETRY_CNT_W;
    localparam int unsigned TM_W = $clog2(RETRY_CYCLES + 1);

    // Refuse settings that the timer or the counter cannot hold
    if (RETRY_CYCLES < 1 || RETRY_LIMIT < 1 || RETRY_LIMIT >= (1 << RC_W))
    begin : g_bad_params
        $error("Unsupported retry parameters");
    end

    // ----------------------------------------------------------------
    // Reset release and input synchronisers
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic       rst_n;
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    localparam int unsigned SW = 5 * N + 9;
    logic [SW-1:0] pin_raw;
    logic [SW-1:0] sync1_reg;
    logic [SW-1:0] sync2_reg;
    assign pin_raw = {direct_in, over_temp, over_current, severe_short, direct_disable,
                      pwm_enable, failsafe_mode, reset_pin, supply_high_protect_disable,
                      logic_supply_fail, supply_por, supply_high, supply_low, status_read};
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
        end
    end

    logic [N-1:0] s_din, s_ot, s_oc, s_sc, s_ddis;
    logic s_pwm, s_fsm, s_rst, s_ovdis, s_lsf, s_por, s_ov, s_uv, s_rd;
    assign {s_din, s_ot, s_oc, s_sc, s_ddis, s_pwm, s_fsm, s_rst, s_ovdis,
            s_lsf, s_por, s_ov, s_uv, s_rd} = sync2_reg;

    // ----------------------------------------------------------------
    // Fault state
    // ----------------------------------------------------------------
    logic [N-1:0]            req_prev_reg, req_prev_next;
    logic [N-1:0]            ot_latch_reg, ot_latch_next;
    logic [N-1:0]            oc_latch_reg, oc_latch_next;
    logic [N-1:0]            sc_latch_reg, sc_latch_next;
    logic [N-1:0]            uv_latch_reg, uv_latch_next;
    logic [N-1:0]            inrush_reg, inrush_next;
    logic [RC_W-1:0]         retry_cnt_reg [N];
    logic [RC_W-1:0]         retry_cnt_next [N];
    logic [TM_W-1:0]         retry_tmr_reg [N];
    logic [TM_W-1:0]         retry_tmr_next [N];
    logic                    fsm_prev_reg, fsm_prev_next;
    fault_latch_pkg::fault_status_t status_reg, status_next;
    logic [N-1:0]            en_reg, en_next;
    logic                    pin_n_reg, pin_n_next;

    logic [N-1:0] turn_on_req;
    logic [N-1:0] req_rise, retry_fire;
    logic         ov_protect, clear_all, mode_change;

    always_comb
    begin
        // Direct input counts only when not disabled and PWM is off
        turn_on_req = (s_din & ~s_ddis & {N{~s_pwm}}) | on_bit;
        req_rise    = turn_on_req & ~req_prev_reg;
        ov_protect  = s_fsm ? s_rst : ~s_ovdis;
        clear_all   = s_lsf | s_por;
        mode_change = s_fsm ^ fsm_prev_reg;

        req_prev_next = turn_on_req;
        fsm_prev_next = s_fsm;
        ot_latch_next = ot_latch_reg;
        oc_latch_next = oc_latch_reg;
        sc_latch_next = sc_latch_reg;
        uv_latch_next = uv_latch_reg;
        inrush_next   = '0;
        retry_fire    = '0;
        for (int i = 0; i < N; i++)
        begin
            retry_cnt_next[i] = retry_cnt_reg[i];
            retry_tmr_next[i] = retry_tmr_reg[i];
        end

        // Clear on read first; hardware sets below win over the clear
        status_next = status_reg;
        if (s_rd)
        begin
            status_next.thermal_shutdown_flags = '0;
            status_next.overcurrent_flags      = '0;
            status_next.short_circuit_flags    = '0;
            status_next.supply_high_flag       = 1'b0;
            status_next.supply_low_flag        = 1'b0;
        end

        for (int i = 0; i < N; i++)
        begin
            // Retry request and timer, per output
            if ((status_reg.overcurrent_flags[i] | status_reg.thermal_shutdown_flags[i]
                 | status_reg.supply_low_flag | oc_latch_reg[i] | ot_latch_reg[i]
                 | uv_latch_reg[i]) && !sc_latch_reg[i]
                && retry_cnt_reg[i] < RC_W'(RETRY_LIMIT))
            begin
                if (retry_tmr_reg[i] == TM_W'(RETRY_CYCLES - 1))
                begin
                    retry_tmr_next[i] = '0;
                    retry_fire[i]     = 1'b1;
                end
                else
                    retry_tmr_next[i] = retry_tmr_reg[i] + TM_W'(1);
            end
            else
                retry_tmr_next[i] = '0;

            if (retry_fire[i])
                retry_cnt_next[i] = retry_cnt_reg[i] + RC_W'(1);

            // Release when the condition is gone and retry or toggle occurs; short latch on toggle only
            if (!s_ot[i] && (retry_fire[i] || req_rise[i]))
                ot_latch_next[i] = 1'b0;
            if (!s_oc[i] && (retry_fire[i] || req_rise[i]))
                oc_latch_next[i] = 1'b0;
            if (!s_uv && (retry_fire[i] || req_rise[i]))
                uv_latch_next[i] = 1'b0;
            if (!s_sc[i] && req_rise[i])
                sc_latch_next[i] = 1'b0;

            // Inrush profile on toggle-on or retry
            inrush_next[i] = req_rise[i] | retry_fire[i] | (inrush_reg[i] & turn_on_req[i]);

            if (s_ot[i])
            begin
                status_next.thermal_shutdown_flags[i] = 1'b1;
                if (turn_on_req[i])
                    ot_latch_next[i] = 1'b1;
            end
            if (s_oc[i] && en_reg[i])
            begin
                oc_latch_next[i] = 1'b1;
                status_next.overcurrent_flags[i] = 1'b1;
            end
            if (s_sc[i] && en_reg[i])
            begin
                sc_latch_next[i] = 1'b1;
                status_next.short_circuit_flags[i] = 1'b1;
            end
            if (s_uv && turn_on_req[i])
                uv_latch_next[i] = 1'b1;

            if (mode_change)
                retry_cnt_next[i] = '0;
        end

        if (s_ov)
            status_next.supply_high_flag = 1'b1;
        if (s_uv)
            status_next.supply_low_flag = 1'b1;

        if (clear_all)
        begin
            ot_latch_next = '0;
            oc_latch_next = '0;
            sc_latch_next = '0;
            uv_latch_next = '0;
        end

        en_next = turn_on_req & ~ot_latch_next & ~oc_latch_next & ~sc_latch_next
                  & ~uv_latch_next & {N{~s_uv}} & {N{~(s_ov & ov_protect)}};

        // Pin low for latches, live overheat while off, supply faults
        pin_n_next = ~(|ot_latch_next | |oc_latch_next | |sc_latch_next | |uv_latch_next
                       | |s_ot | (s_ov & ov_protect) | s_uv);
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_prev_reg <= '0;
            fsm_prev_reg <= 1'b0;
            ot_latch_reg <= '0;
            oc_latch_reg <= '0;
            sc_latch_reg <= '0;
            uv_latch_reg <= '0;
            inrush_reg   <= '0;
            status_reg   <= fault_latch_pkg::STATUS_RESET;
            en_reg       <= '0;
            pin_n_reg    <= 1'b1;
            for (int i = 0; i < N; i++)
            begin
                retry_cnt_reg[i] <= '0;
                retry_tmr_reg[i] <= '0;
            end
        end
        else
        begin
            req_prev_reg <= req_prev_next;
            fsm_prev_reg <= fsm_prev_next;
            ot_latch_reg <= ot_latch_next;
            oc_latch_reg <= oc_latch_next;
            sc_latch_reg <= sc_latch_next;
            uv_latch_reg <= uv_latch_next;
            inrush_reg   <= inrush_next;
            status_reg   <= status_next;
            en_reg       <= en_next;
            pin_n_reg    <= pin_n_next;
            for (int i = 0; i < N; i++)
            begin
                retry_cnt_reg[i] <= retry_cnt_next[i];
                retry_tmr_reg[i] <= retry_tmr_next[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // Over-current configuration applied to the detector
    // ----------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            oc_apply[i].inrush_active = inrush_reg[i];
            oc_apply[i].profile       = oc_cfg[i].profile;
            // Retry uses defaults so the inrush is tolerated
            oc_apply[i].inrush_slope_select  = retry_cnt_reg[i] != '0 && inrush_reg[i]
                ? fault_latch_pkg::INRUSH_SLOPE_DEFAULT : oc_cfg[i].inrush_slope_select;
            oc_apply[i].skip_first_high_step = inrush_reg[i] && retry_cnt_reg[i] != '0
                ? 1'b0 : oc_cfg[i].skip_first_high_step;
            unique case (oc_cfg[i].steady_limit_select)
                2'h0: oc_apply[i].steady_level = fault_latch_pkg::LEVEL_LOW2;
                2'h1: oc_apply[i].steady_level = fault_latch_pkg::LEVEL_LOW1;
                2'h2: oc_apply[i].steady_level = fault_latch_pkg::LEVEL_LOW3;
                2'h3: oc_apply[i].steady_level = fault_latch_pkg::LEVEL_LOW4;
            endcase
            oc_apply[i].cooling_active = !s_fsm && s_pwm && oc_cfg[i].cooling_emulation_enable
                && oc_cfg[i].profile == fault_latch_pkg::PROFILE_HID;
            oc_apply[i].cooling_slope_select = oc_cfg[i].cooling_slope_select;
            retry_exhausted[i] = retry_cnt_reg[i] >= RC_W'(RETRY_LIMIT);
        end
    end

    assign output_enable = en_reg;
    assign status        = status_reg;
    assign fault_pin_n   = pin_n_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_OT_ON_LATCH: assert property ((s_ot[0] && turn_on_req[0] && !clear_all)
        |=> !en_reg[0] && !fault_pin_n) else $error("overheat did not latch");
    AST_OT_FLAG: assert property (s_ot[1] |=> status_reg.thermal_shutdown_flags[1])
        else $error("thermal flag not set");
    AST_OC_FLAG: assert property ((s_oc[0] && en_reg[0] && !clear_all)
        |=> oc_latch_reg[0] && status_reg.overcurrent_flags[0])
        else $error("overcurrent not latched");
    AST_SC_NO_RETRY: assert property ((sc_latch_reg[2] && !req_rise[2] && !clear_all)
        |=> sc_latch_reg[2]) else $error("short released without toggle");
    AST_OV_OFF: assert property ((s_ov && ov_protect) |=> output_enable == '0)
        else $error("over-voltage left output on");
    AST_UV_OFF: assert property (s_uv
        |=> output_enable == '0 && status_reg.supply_low_flag)
        else $error("under-voltage not handled");
    AST_CLEAR_ALL: assert property (clear_all
        |=> ot_latch_reg == '0 && sc_latch_reg == '0) else $error("latches survived supply loss");
    AST_RETRY_LIMIT: assert property (retry_cnt_reg[0] <= RC_W'(RETRY_LIMIT))
        else $error("retry count exceeded");
    AST_MODE_RESET: assert property (mode_change |=> retry_cnt_reg[3] == '0)
        else $error("retry counter kept on mode change");
    AST_INRUSH: assert property (req_rise[1] |=> oc_apply[1].inrush_active)
        else $error("inrush not applied");

    COV_RETRY: cover property (retry_fire[0]);
    COV_EXHAUST: cover property (retry_exhausted[0]);
    COV_OV: cover property (s_ov && !ov_protect);
    COV_READ_CLEAR: cover property (s_rd && status_reg.overcurrent_flags != '0);

endmodule

// File: host_model.sv
// Host controller model: turn-on requests and timed status reads
`timescale 1ns/1ps

module host_model #(
    parameter logic [3:0] READ_LEN = 4'h4
) (
    input  wire logic                                    core_clk,
    input  wire logic                                    arst_n,
    input  wire logic                                    read_req,
    input  wire logic [fault_latch_pkg::NUM_OUTPUTS-1:0] on_cmd,
    output logic                                         status_read,
    output logic [fault_latch_pkg::NUM_OUTPUTS-1:0]      on_bit
);
    logic [3:0] read_cnt_reg;
    logic [3:0] read_cnt_next;

    always_comb
    begin
        read_cnt_next = read_cnt_reg;
        if (read_req)
            read_cnt_next = READ_LEN;
        else if (read_cnt_reg != 4'h0)
            read_cnt_next = read_cnt_reg - 4'h1;
    end

    // Turn-on requests follow the command one edge later; off-then-on toggles release latches
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            read_cnt_reg <= 4'h0;
            on_bit       <= '0;
        end
        else
        begin
            read_cnt_reg <= read_cnt_next;
            on_bit       <= on_cmd;
        end
    end

    // Held several cycles so the synchronised read strobe is seen at least once
    assign status_read = (read_cnt_reg != 4'h0);
endmodule

// File: tb_top.sv
// Self-checking testbench for the output fault latch and retry block
`timescale 1ns/1ps

module tb_top;
    localparam int unsigned RETRY_T = 40;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] direct_in = '0, direct_disable = '0, on_cmd = '0, on_bit;
    logic [3:0] over_temp = '0, over_current = '0, severe_short = '0;
    logic [3:0] output_enable, retry_exhausted;
    logic pwm_enable = 0, failsafe_mode = 0, reset_pin = 0, supply_high_protect_disable = 0;
    logic logic_supply_fail = 0, supply_por = 0, supply_high = 0, supply_low = 0;
    logic status_read, read_req = 0, fault_pin_n;
    fault_latch_pkg::oc_cfg_t [3:0]   oc_cfg = '0;
    fault_latch_pkg::oc_apply_t [3:0] oc_apply;
    fault_latch_pkg::fault_status_t   status;
    int err_count = 0, n_checks = 0, i, c, k;
    logic [31:0] seed, r;
    logic [1:0] ca, cb, cc;

    always #5 core_clk = ~core_clk;

    output_fault_latch_retry #(.RETRY_CYCLES(RETRY_T), .RETRY_LIMIT(fault_latch_pkg::RETRY_LIMIT))
        output_fault_latch_retry_inst (.core_clk, .arst_n, .direct_in, .direct_disable, .on_bit,
        .pwm_enable, .failsafe_mode, .reset_pin, .supply_high_protect_disable, .logic_supply_fail,
        .supply_por, .over_temp, .over_current, .severe_short, .supply_high, .supply_low, .oc_cfg,
        .status_read, .output_enable, .oc_apply, .status, .fault_pin_n, .retry_exhausted);

    host_model host_model_inst (.core_clk, .arst_n, .read_req, .on_cmd, .status_read, .on_bit);

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic host_read();
        read_req <= 1'b1;
        cyc(1);
        read_req <= 1'b0;
        cyc(10);
    endtask

    task automatic wait_on(input logic [1:0] ch);
        k = 0;
        while (output_enable[ch] !== 1'b1 && k < 200)
        begin
            cyc(1);
            k++;
        end
    endtask

    function automatic logic [1:0] exp_level(input logic [1:0] sel);
        case (sel)
            2'h0:    return fault_latch_pkg::LEVEL_LOW2;
            2'h1:    return fault_latch_pkg::LEVEL_LOW1;
            2'h2:    return fault_latch_pkg::LEVEL_LOW3;
            default: return fault_latch_pkg::LEVEL_LOW4;
        endcase
    endfunction

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // -----------------------------------------
    // Watchdog: the sequence needs under two thousand cycles
    // -----------------------------------------
    initial
    begin
        cyc(20000);
        err_count++;
        conclude();
    end

    initial
    begin
        seed = 32'h5bad8802;
        r = $random(seed);
        ca = r[1:0];
        cb = ca ^ 2'h1;
        cc = ca ^ 2'h2;
        cyc(2);
        arst_n <= 1'b1;
        cyc(4);
        check(status, fault_latch_pkg::STATUS_RESET);
        // Random configurations against the applied detector settings
        for (i = 0; i < 8; i++)
        begin
            for (c = 0; c < 4; c++)
            begin
                r = $random(seed);
                oc_cfg[c] <= {2'(r[1:0] % 3), r[9:2]};
            end
            pwm_enable <= i[0];
            cyc(8);
            for (c = 0; c < 4; c++)
            begin
                check(oc_apply[c].profile, oc_cfg[c].profile);
                check(oc_apply[c].steady_level, exp_level(oc_cfg[c].steady_limit_select));
                check(oc_apply[c].inrush_slope_select, oc_cfg[c].inrush_slope_select);
                check(oc_apply[c].skip_first_high_step, oc_cfg[c].skip_first_high_step);
                check(oc_apply[c].cooling_active, oc_cfg[c].cooling_emulation_enable
                    && oc_cfg[c].profile == fault_latch_pkg::PROFILE_HID && pwm_enable);
                check(oc_apply[c].cooling_slope_select, oc_cfg[c].cooling_slope_select);
            end
        end
        pwm_enable <= 1'b0;
        $display("test config done");
        direct_in[ca] <= 1'b1;
        cyc(8);
        check(output_enable[ca], 1'b1);
        direct_disable[ca] <= 1'b1;
        cyc(8);
        check(output_enable[ca], 1'b0);
        direct_in[ca] <= 1'b0;
        direct_disable[ca] <= 1'b0;
        on_cmd[ca] <= 1'b1;
        cyc(8);
        check(output_enable[ca], 1'b1);
        $display("test request done");
        over_temp[ca] <= 1'b1;
        cyc(8);
        check({output_enable[ca], fault_pin_n}, 2'b00);
        check(status.thermal_shutdown_flags[ca], 1'b1);
        over_temp[ca] <= 1'b0;
        wait_on(ca);
        check(output_enable[ca], 1'b1);
        host_read();
        check(status.thermal_shutdown_flags[ca], 1'b0);
        on_cmd[ca] <= 1'b0;
        over_temp[ca] <= 1'b1;
        cyc(8);
        check(fault_pin_n, 1'b0);
        over_temp[ca] <= 1'b0;
        cyc(8);
        check({fault_pin_n, status.thermal_shutdown_flags[ca]}, 2'b11);
        host_read();
        $display("test thermal done");
        oc_cfg[cb] <= {fault_latch_pkg::PROFILE_BULB_28W, 2'h3, 1'b1, 2'h2, 3'h0};
        on_cmd[cb] <= 1'b1;
        cyc(8);
        over_current[cb] <= 1'b1;
        cyc(8);
        check({output_enable[cb], fault_pin_n}, 2'b00);
        check(status.overcurrent_flags[cb], 1'b1);
        check(oc_apply[cb].inrush_slope_select, 2'h3);
        // Inrush is held from the toggle-on; wait past the first retry for defaults
        cyc(RETRY_T);
        check(oc_apply[cb].inrush_active, 1'b1);
        check(oc_apply[cb].inrush_slope_select, fault_latch_pkg::INRUSH_SLOPE_DEFAULT);
        check(oc_apply[cb].skip_first_high_step, 1'b0);
        k = 0;
        while (retry_exhausted[cb] !== 1'b1 && k < 3000)
        begin
            cyc(1);
            k++;
        end
        check(retry_exhausted, 4'h1 << cb);
        over_current[cb] <= 1'b0;
        cyc(3 * RETRY_T);
        check(output_enable[cb], 1'b0);
        failsafe_mode <= 1'b1;
        cyc(8);
        check(retry_exhausted[cb], 1'b0);
        wait_on(cb);
        host_read();
        $display("test overcurrent done");
        supply_high <= 1'b1;
        cyc(8);
        check(output_enable[cb], 1'b1);
        reset_pin <= 1'b1;
        cyc(8);
        check({output_enable[cb], fault_pin_n}, 2'b00);
        supply_high <= 1'b0;
        cyc(8);
        check({output_enable[cb], status.supply_high_flag}, 2'b11);
        host_read();
        check(status.supply_high_flag, 1'b0);
        failsafe_mode <= 1'b0;
        supply_high_protect_disable <= 1'b1;
        supply_high <= 1'b1;
        cyc(8);
        host_read();
        check({output_enable[cb], status.supply_high_flag}, 2'b11);
        supply_high <= 1'b0;
        cyc(8);
        host_read();
        check(status.supply_high_flag, 1'b0);
        supply_high_protect_disable <= 1'b0;
        $display("test supply high done");
        on_cmd[cc] <= 1'b1;
        cyc(8);
        severe_short[cc] <= 1'b1;
        cyc(8);
        check({output_enable[cc], status.short_circuit_flags[cc]}, 2'b01);
        severe_short[cc] <= 1'b0;
        cyc(4 * RETRY_T);
        check({output_enable[cc], fault_pin_n}, 2'b00);
        on_cmd[cc] <= 1'b0;
        cyc(3);
        on_cmd[cc] <= 1'b1;
        cyc(8);
        check(output_enable[cc], 1'b1);
        severe_short[cc] <= 1'b1;
        cyc(8);
        severe_short[cc] <= 1'b0;
        logic_supply_fail <= 1'b1;
        cyc(8);
        logic_supply_fail <= 1'b0;
        cyc(8);
        check(output_enable[cc], 1'b1);
        host_read();
        $display("test short done");
        on_cmd <= '0;
        cyc(8);
        supply_low <= 1'b1;
        cyc(8);
        check({fault_pin_n, status.supply_low_flag}, 2'b01);
        supply_low <= 1'b0;
        cyc(8);
        check({fault_pin_n, status.supply_low_flag}, 2'b11);
        host_read();
        check(status.supply_low_flag, 1'b0);
        on_cmd[ca] <= 1'b1;
        cyc(8);
        supply_low <= 1'b1;
        cyc(8);
        check(output_enable[ca], 1'b0);
        supply_low <= 1'b0;
        wait_on(ca);
        check(output_enable[ca], 1'b1);
        $display("test supply low done");
        conclude();
    end
endmodule
